// *** ntsc_assertions.sv ***
`timescale 1ns/1ps
module ntsc_assertions
    import ntsc_pkg::*;
#(
    parameter int TUNE_CYC = NTSC_TUNE_CYC
)(
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [3:0] notch_select_n_i,
    input wire logic spi_clk_i,
    input wire logic spi_mosi_i,
    input wire logic [3:0] tune_done_o,
    input wire logic passband_disrupt_flag_o,
    input wire logic [3:0] bypass_bit_o,
    input wire logic [51:0] tune_addr_o
);
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    logic [15:0] low_ff;
    logic [15:0] flag_ff;
    logic [15:0] nxt_low;
    logic [15:0] nxt_flag;
    always_comb begin
        nxt_low = tune_done_o[0] ? 16'h0000 : low_ff + 16'h0001;
        nxt_flag = passband_disrupt_flag_o ? flag_ff + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge clock_i) begin
        low_ff <= srst_i ? 16'h0000 : nxt_low;
        flag_ff <= srst_i ? 16'h0000 : nxt_flag;
    end
    sequence done_fall_s;
        $fell(tune_done_o[0]);
    endsequence
    chk_reset_idle: assert property ($fell(srst_i) |-> tune_done_o == 4'hF
        && !passband_disrupt_flag_o && bypass_bit_o == 4'hF)
        else $error("state after reset wrong");
    chk_flag_short: assert property (passband_disrupt_flag_o |->
        flag_ff < NTSC_DISRUPT_CYC) else $error("disruption too long");
    chk_bypass_flag: assert property ($changed(bypass_bit_o) |->
        ##[0:1] passband_disrupt_flag_o) else $error("no flag on bypass");
    chk_addr_flag: assert property ($changed(tune_addr_o) |->
        ##[0:1] passband_disrupt_flag_o) else $error("no flag on retune");
    chk_done_time: assert property ($rose(tune_done_o[0]) |->
        low_ff >= TUNE_CYC - 1) else $error("retune ended early");
    chk_tune_bound: assert property (low_ff <= TUNE_CYC + 1)
        else $error("retune too long");
    chk_own_select: assert property (done_fall_s |->
        !$past(notch_select_n_i[0], 3)) else $error("unselected retune");
    chk_zone_kept: assert property (tune_addr_o[12:0] inside
        {13'h0000, [NTSC_ZONE_LO_1:NTSC_ZONE_LO_2 - 13'h0001]})
        else $error("notch one out of zone");
endmodule

bind ntsc_top ntsc_assertions #(.TUNE_CYC(TUNE_CYC)) u_chk(
    .clock_i(clock_i), .srst_i(srst_i),
    .notch_select_n_i(notch_select_n_i), .spi_clk_i(spi_clk_i),
    .spi_mosi_i(spi_mosi_i), .tune_done_o(tune_done_o),
    .passband_disrupt_flag_o(passband_disrupt_flag_o),
    .bypass_bit_o(bypass_bit_o), .tune_addr_o(tune_addr_o));

// *** ntsc_host_model.sv ***
`timescale 1ns/1ps
module ntsc_host_model (
    input wire logic clock_i,
    output logic [3:0] sel_n_o,
    output logic sclk_o,
    output logic mosi_o
);
    int half_cyc = 5;
    initial begin
        sel_n_o = 4'hF;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
    end
    task automatic half();
        repeat (half_cyc) @(negedge clock_i);
    endtask
    task automatic send(input logic [3:0] m, input logic [15:0] w,
                        input int n);
        sel_n_o = ~m;
        half();
        for (int i = 15; i > 15 - n; i--) begin
            mosi_o = w[i];
            half();
            sclk_o = 1'b1;
            half();
            sclk_o = 1'b0;
        end
        // The data line is not held after the frame, so flip it.
        mosi_o = ~mosi_o;
        half();
        sel_n_o = 4'hF;
        half();
    endtask
endmodule

// *** ntsc_pkg.sv ***
package ntsc_pkg;
    localparam int NTSC_CHANNELS = 4;
    localparam int NTSC_WORD_BITS = 16;
    localparam int NTSC_ADDR_BITS = 13;
    localparam int NTSC_BYPASS_POS = 15;
    localparam int NTSC_ZERO_HI_POS = 14;
    localparam int NTSC_ZERO_LO_POS = 13;
    localparam int NTSC_CLK_HZ = 40_000_000;
    localparam int NTSC_CLK_NS = 1_000_000_000 / NTSC_CLK_HZ;
    // Retune completion time in ns and disruption pulse in ns.
    localparam int NTSC_TUNE_NS = 50_000;
    localparam int NTSC_DISRUPT_NS = 2_600;
    // Pin synchroniser, edge detect and word strobe delay the start of the
    // retune count, so the count is cut by that delay to keep the bound.
    localparam int NTSC_SYNC_LAT_CYC = 5;
    localparam int NTSC_TUNE_CYC =
        NTSC_TUNE_NS / NTSC_CLK_NS - NTSC_SYNC_LAT_CYC;
    localparam int NTSC_DISRUPT_CYC = NTSC_DISRUPT_NS / NTSC_CLK_NS;
    localparam logic [12:0] NTSC_ADDR_RESET = 13'h0000;
    localparam logic [12:0] NTSC_ZONE_LO_1 = 13'h08CA;
    localparam logic [12:0] NTSC_ZONE_LO_2 = 13'h0BB8;
    localparam logic [12:0] NTSC_ZONE_LO_3 = 13'h0EA6;
    localparam logic [12:0] NTSC_ZONE_LO_4 = 13'h1194;
    localparam logic [12:0] NTSC_ZONE_HI_4 = 13'h1400;
    localparam logic [4:0] NTSC_BITCNT_LAST = 5'h10;
    typedef enum logic [1:0] {
        NTSC_IDLE = 2'b00,
        NTSC_TUNE = 2'b01,
        NTSC_HOLD = 2'b11
    } ntsc_state_t;
endpackage

// *** ntsc_shift_if.sv ***
`timescale 1ns/1ps
interface ntsc_shift_if;
    logic sel_active;
    logic clk_rise;
    logic data_bit;
    logic word_valid;
    logic [15:0] word;
    modport shifter(input sel_active, clk_rise, data_bit,
                    output word_valid, word);
    modport ctrl(output sel_active, clk_rise, data_bit,
                 input word_valid, word);
endinterface

// *** ntsc_shifter.sv ***
`timescale 1ns/1ps
module ntsc_shifter
    import ntsc_pkg::*;
(
    input wire logic clock_i,
    input wire logic srst_i,
    ntsc_shift_if.shifter sh
);
    logic [15:0] word_ff, nxt_word;
    logic [4:0] cnt_ff, nxt_cnt;
    logic valid_ff, nxt_valid;

    always_comb begin
        nxt_word = word_ff;
        nxt_cnt = cnt_ff;
        nxt_valid = 1'b0;
        if (!sh.sel_active) begin
            nxt_cnt = '0;
        end else if (sh.clk_rise && cnt_ff < NTSC_BITCNT_LAST) begin
            nxt_word = {word_ff[14:0], sh.data_bit};
            nxt_cnt = cnt_ff + 5'h01;
            nxt_valid = (cnt_ff == NTSC_BITCNT_LAST - 5'h01);
        end
    end

    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            word_ff <= '0;
            cnt_ff <= '0;
            valid_ff <= 1'b0;
        end else begin
            word_ff <= nxt_word;
            cnt_ff <= nxt_cnt;
            valid_ff <= nxt_valid;
        end
    end

    assign sh.word = word_ff;
    assign sh.word_valid = valid_ff;
endmodule

// *** ntsc_top.sv ***
`timescale 1ns/1ps
module ntsc_top
    import ntsc_pkg::*;
#(
    parameter int TUNE_CYC = NTSC_TUNE_CYC
)(
    input wire logic clock_i,
    input wire logic srst_i,
    input wire logic [3:0] notch_select_n_i,
    input wire logic spi_clk_i,
    input wire logic spi_mosi_i,
    output logic [3:0] tune_done_o,
    output logic passband_disrupt_flag_o,
    output logic [3:0] bypass_bit_o,
    output logic [51:0] tune_addr_o
);
    // The retune counter is sixteen bits wide.
    if (TUNE_CYC < 1 || TUNE_CYC > 65535) begin : g_bad_tune_cyc
        $error("TUNE_CYC out of range");
    end

    // Two flops on every pin; only stage two is read by logic.
    logic [5:0] sync1_ff, sync2_ff, nxt_sync1, nxt_sync2;
    logic clk_prev_ff, nxt_clk_prev;
    always_comb begin
        nxt_sync1 = {spi_mosi_i, spi_clk_i, notch_select_n_i};
        nxt_sync2 = sync1_ff;
        nxt_clk_prev = sync2_ff[4];
    end
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            sync1_ff <= 6'h0F;
            sync2_ff <= 6'h0F;
            clk_prev_ff <= 1'b0;
        end else begin
            sync1_ff <= nxt_sync1;
            sync2_ff <= nxt_sync2;
            clk_prev_ff <= nxt_clk_prev;
        end
    end

    logic [3:0] sel_n;
    assign sel_n = sync2_ff[3:0];

    // frame opens on select fall
    // Only a notch whose select fell and has stayed low since takes its
    // word. A fresh fall also restarts the shared bit count, so a host that
    // keeps one notch selected cannot lock out frames aimed at the others.
    logic [3:0] sel_prev_ff, nxt_sel_prev, open_ff, nxt_open, sel_fall;
    always_comb begin
        sel_fall = sel_prev_ff & ~sel_n;
        nxt_sel_prev = sel_n;
        nxt_open = (open_ff | sel_fall) & ~sel_n;
    end
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            sel_prev_ff <= 4'hF;
            open_ff <= 4'h0;
        end else begin
            sel_prev_ff <= nxt_sel_prev;
            open_ff <= nxt_open;
        end
    end

    ntsc_shift_if sh();
    // Single shared shifter: any low select enables it, and a select fall
    // forces one idle cycle so that every frame starts from bit zero.
    assign sh.sel_active = ~&sel_n & ~|sel_fall;
    assign sh.clk_rise = sync2_ff[4] & ~clk_prev_ff;
    assign sh.data_bit = sync2_ff[5];

    ntsc_shifter u_shift (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .sh(sh)
    );

    logic [12:0] zone_lo [NTSC_CHANNELS+1];
    assign zone_lo[0] = NTSC_ZONE_LO_1;
    assign zone_lo[1] = NTSC_ZONE_LO_2;
    assign zone_lo[2] = NTSC_ZONE_LO_3;
    assign zone_lo[3] = NTSC_ZONE_LO_4;
    assign zone_lo[4] = NTSC_ZONE_HI_4 + 13'h0001;

    logic [3:0] done_ff, nxt_done, byp_ff, nxt_byp, chg;
    logic [12:0] addr_ff [NTSC_CHANNELS];
    logic [12:0] nxt_addr [NTSC_CHANNELS];
    ntsc_state_t st_ff [NTSC_CHANNELS];
    ntsc_state_t nxt_st [NTSC_CHANNELS];
    logic [15:0] tcnt_ff [NTSC_CHANNELS];
    logic [15:0] nxt_tcnt [NTSC_CHANNELS];

    genvar g;
    generate
        for (g = 0; g < NTSC_CHANNELS; g++) begin : g_ch
            logic hit, in_zone, zeros_ok;
            assign hit = sh.word_valid & ~sel_n[g] & open_ff[g];
            assign in_zone = sh.word[12:0] >= zone_lo[g] &&
                             sh.word[12:0] < zone_lo[g+1];
            assign zeros_ok = ~sh.word[NTSC_ZERO_HI_POS] &
                              ~sh.word[NTSC_ZERO_LO_POS];
            always_comb begin
                nxt_st[g] = st_ff[g];
                nxt_tcnt[g] = tcnt_ff[g];
                nxt_addr[g] = addr_ff[g];
                nxt_byp[g] = byp_ff[g];
                nxt_done[g] = done_ff[g];
                chg[g] = 1'b0;
                unique case (st_ff[g])
                    NTSC_IDLE: begin
                        nxt_done[g] = 1'b1;
                        if (hit && zeros_ok) begin
                            // out of zone keeps old state unless the bypass bit is set
                            if (in_zone || sh.word[NTSC_BYPASS_POS]) begin
                                nxt_byp[g] = sh.word[NTSC_BYPASS_POS];
                                if (in_zone) begin
                                    nxt_addr[g] = sh.word[12:0];
                                end
                                chg[g] = (nxt_addr[g] != addr_ff[g]) ||
                                         (nxt_byp[g] != byp_ff[g]);
                                nxt_done[g] = 1'b0;
                                nxt_tcnt[g] = 16'(TUNE_CYC - 1);
                                nxt_st[g] = NTSC_TUNE;
                            end
                        end
                    end
                    NTSC_TUNE: begin
                        if (tcnt_ff[g] == 16'h0000) begin
                            nxt_done[g] = 1'b1;
                            nxt_st[g] = NTSC_HOLD;
                        end else begin
                            nxt_tcnt[g] = tcnt_ff[g] - 16'h0001;
                        end
                    end
                    NTSC_HOLD: begin
                        // Words arriving here are dropped until select rises.
                        // wait for select high
                        if (sel_n[g]) begin
                            nxt_st[g] = NTSC_IDLE;
                        end
                    end
                    default: nxt_st[g] = NTSC_IDLE;
                endcase
            end
            always_ff @(posedge clock_i) begin
                if (srst_i) begin
                    st_ff[g] <= NTSC_IDLE;
                    tcnt_ff[g] <= '0;
                    addr_ff[g] <= NTSC_ADDR_RESET;
                    byp_ff[g] <= 1'b1;
                    done_ff[g] <= 1'b1;
                end else begin
                    st_ff[g] <= nxt_st[g];
                    tcnt_ff[g] <= nxt_tcnt[g];
                    addr_ff[g] <= nxt_addr[g];
                    byp_ff[g] <= nxt_byp[g];
                    done_ff[g] <= nxt_done[g];
                end
            end
            assign tune_addr_o[g*13 +: 13] = addr_ff[g];
        end
    endgenerate

    // Disruption pulse, restarted by each new change.
    logic [7:0] pcnt_ff, nxt_pcnt;
    logic pb_ff, nxt_pb;
    always_comb begin
        nxt_pcnt = pcnt_ff;
        nxt_pb = pb_ff;
        if (|chg) begin
            nxt_pcnt = 8'(NTSC_DISRUPT_CYC - 1);
            nxt_pb = 1'b1;
        end else if (pcnt_ff != 8'h00) begin
            nxt_pcnt = pcnt_ff - 8'h01;
        end else begin
            nxt_pb = 1'b0;
        end
    end
    always_ff @(posedge clock_i) begin
        if (srst_i) begin
            pcnt_ff <= '0;
            pb_ff <= 1'b0;
        end else begin
            pcnt_ff <= nxt_pcnt;
            pb_ff <= nxt_pb;
        end
    end

    assign tune_done_o = done_ff;
    assign bypass_bit_o = byp_ff;
    assign passband_disrupt_flag_o = pb_ff;
endmodule

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench
    import ntsc_pkg::*;
;
    localparam int TC = 20;
    logic clock_i = 1'b0;
    logic srst_i = 1'b1;
    logic [3:0] sel_n;
    logic sclk;
    logic mosi;
    logic [3:0] done;
    logic flag;
    logic [3:0] byp;
    logic [51:0] addr;
    logic [3:0] exp_byp = 4'hF;
    logic [51:0] exp_addr = '0;
    logic [3:0] low_seen = 4'h0;
    logic flag_seen = 1'b0;
    logic [12:0] lo [4] = '{NTSC_ZONE_LO_1, NTSC_ZONE_LO_2,
                           NTSC_ZONE_LO_3, NTSC_ZONE_LO_4};
    logic [12:0] hi [4] = '{NTSC_ZONE_LO_2 - 13'h0001,
                           NTSC_ZONE_LO_3 - 13'h0001,
                           NTSC_ZONE_LO_4 - 13'h0001, NTSC_ZONE_HI_4};
    int error_cnt = 0;
    int checks_done = 0;
    int cyc = 0;
    always #12.5 clock_i = ~clock_i;
    ntsc_top #(.TUNE_CYC(TC)) dut(.clock_i(clock_i), .srst_i(srst_i),
        .notch_select_n_i(sel_n), .spi_clk_i(sclk), .spi_mosi_i(mosi),
        .tune_done_o(done), .passband_disrupt_flag_o(flag),
        .bypass_bit_o(byp), .tune_addr_o(addr));
    ntsc_host_model host(.clock_i(clock_i), .sel_n_o(sel_n),
        .sclk_o(sclk), .mosi_o(mosi));
    always @(posedge clock_i) begin
        low_seen <= low_seen | ~done;
        flag_seen <= flag_seen | flag;
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            finish_test();
        end
    end
    task automatic check(input logic [51:0] seen, input logic [51:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic word(input logic [3:0] m, input logic [15:0] w,
                        input int n, input logic [3:0] acc);
        logic chg;
        chg = 1'b0;
        for (int k = 0; k < 4; k++) begin
            if (acc[k]) begin
                chg |= exp_byp[k] != w[15];
                exp_byp[k] = w[15];
                // An address outside the notch's zone is kept as it was.
                if (w[12:0] >= lo[k] && w[12:0] <= hi[k]) begin
                    chg |= exp_addr[k*13+:13] != w[12:0];
                    exp_addr[k*13+:13] = w[12:0];
                end
            end
        end
        check(done, 4'hF);
        low_seen = 4'h0;
        flag_seen = 1'b0;
        host.send(m, w, n);
        for (int i = 0; i < TC + 40 && done !== 4'hF; i++) begin
            @(negedge clock_i);
        end
        check(done, 4'hF);
        check(low_seen, acc);
        check(flag_seen, chg);
        check(byp, exp_byp);
        check(addr, exp_addr);
        repeat (110) @(negedge clock_i);
        check(flag, 1'b0);
    endtask
    task automatic t_reset();
        check({flag, byp, done}, 9'h0FF);
        check(addr, 52'h0);
        $display("reset test done");
    endtask
    task automatic t_all();
        for (int k = 0; k < 4; k++) begin
            word(4'h1 << k, {3'b000, lo[k]}, 16, 4'h1 << k);
            word(4'h1 << k, {3'b100, lo[k]}, 16, 4'h1 << k);
        end
        $display("notch test done");
    endtask
    task automatic t_edges();
        host.half_cyc = 8;
        word(4'h8, 16'h1400, 16, 4'h8);
        word(4'h6, 16'h0EA5, 16, 4'h2);
        word(4'h1, 16'h0BB7, 16, 4'h1);
        word(4'h1, 16'h8000, 16, 4'h1);
        host.half_cyc = 5;
        $display("edge test done");
    endtask
    task automatic t_refuse();
        word(4'h8, 16'h5194, 16, 4'h0);
        word(4'h8, 16'h3194, 16, 4'h0);
        word(4'h8, 16'h1401, 16, 4'h0);
        word(4'h1, 16'h0BB8, 16, 4'h0);
        word(4'h8, 16'h1194, 8, 4'h0);
        $display("refuse test done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(negedge clock_i);
        srst_i = 1'b0;
        repeat (2) @(negedge clock_i);
        t_reset();
        t_all();
        t_edges();
        t_refuse();
        finish_test();
    end
endmodule
